// ---- rtcs_pkg.sv ----
// Shared constants and types for the real-time clock serial slave port.
package rtcs_pkg;

    // ------------------------------------------------------------
    // Bus addressing
    // ------------------------------------------------------------
    localparam logic [7:0] SLAVE_ADDR   = 8'hD0;
    localparam int         PTR_W        = 6;
    localparam logic [5:0] LOC_CLOCK_LO = 6'h00;
    localparam logic [5:0] LOC_CLOCK_HI = 6'h07;
    localparam logic [5:0] LOC_CONTROL  = 6'h08;
    localparam logic [5:0] LOC_WATCHDOG = 6'h09;
    localparam logic [5:0] LOC_ALARM_LO = 6'h0A;
    localparam logic [5:0] LOC_RSVD_LO  = 6'h10;
    localparam logic [5:0] LOC_SQWAVE   = 6'h13;
    localparam logic [5:0] LOC_RAM_LO   = 6'h14;
    localparam logic [5:0] LOC_RAM_HI   = 6'h3F;
    localparam logic [3:0] BITS_BYTE    = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ         = 125;
    localparam int FIFO_DEPTH      = 8;
    localparam int SYNC_RST_PINS   = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PTR_W-1:0] addr;
        logic [7:0]       data;
    } rtcs_wr_t;

    typedef struct packed {
        logic pfail;
        logic sda;
        logic scl;
    } rtcs_pins_t;

    localparam rtcs_pins_t PINS_RESET = 3'h3;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_ADDR      = 4'b0001,
        ST_ADDR_ACK  = 4'b0010,
        ST_WADDR     = 4'b0011,
        ST_WADDR_ACK = 4'b0100,
        ST_WDATA     = 4'b0101,
        ST_WPUSH     = 4'b0110,
        ST_WDATA_ACK = 4'b0111,
        ST_RLOAD     = 4'b1000,
        ST_RDATA     = 4'b1001,
        ST_RACK      = 4'b1010,
        ST_WAIT      = 4'b1011
    } rtcs_state_t;

endpackage : rtcs_pkg

// ---- rtcs_sync.sv ----
// Two-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/10ps
`default_nettype none
module rtcs_sync #(
    parameter int               W         = 3,
    parameter logic [W-1:0]     RESET_VAL = '0
) (
    input  wire logic           i_core_clk,
    input  wire logic           i_rst,
    input  wire logic [W-1:0]   i_async,
    output logic      [W-1:0]   o_sync
);
    logic [W-1:0] meta;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            meta   <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule : rtcs_sync
`default_nettype wire

// ---- rtcs_fifo.sv ----
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module rtcs_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rd_ptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : rtcs_fifo
`default_nettype wire

// ---- rtcs_slave.sv ----
// Two-wire serial slave port of the real-time clock: protocol engine, pointer and power-fail guard.
`timescale 1ns/10ps
`default_nettype none
module rtcs_slave #(
    parameter int RECOVERY_DELAY_US = 1000
) (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst,
    // Serial bus pins, both open drain.
    input  wire logic                    i_scl,
    output logic                         o_scl_o,
    output logic                         o_scl_oe,
    input  wire logic                    i_sda,
    output logic                         o_sda_o,
    output logic                         o_sda_oe,
    // Supply monitor.
    input  wire logic                    i_power_fail,
    // Write stream towards the register and RAM array.
    output logic                         o_wr_valid,
    input  wire logic                    i_wr_ready,
    output logic [rtcs_pkg::PTR_W-1:0]   o_wr_addr,
    output logic [7:0]                   o_wr_data,
    // Read port into the register and RAM array.
    output logic [rtcs_pkg::PTR_W-1:0]   o_rd_addr,
    output logic                         o_rd_strobe,
    input  wire logic [7:0]              i_rd_data,
    // Status towards the timekeeping logic.
    output logic                         o_clock_freeze,
    output logic                         o_access_blocked,
    output logic                         o_bus_busy
);

    // ------------------------------------------------------------
    // Recovery delay in core clock cycles
    // ------------------------------------------------------------
    localparam int REC_CYCLES = RECOVERY_DELAY_US * rtcs_pkg::CLK_MHZ;
    localparam int REC_W      = $clog2(REC_CYCLES + 1);

    // ------------------------------------------------------------
    // Pin synchronisation and condition detection
    // ------------------------------------------------------------
    rtcs_pkg::rtcs_pins_t pins_async;
    rtcs_pkg::rtcs_pins_t pins_sync;
    logic                 scl_q;
    logic                 sda_q;
    logic                 scl_rise;
    logic                 scl_fall;
    logic                 start_cond;
    logic                 stop_cond;

    assign pins_async.pfail = i_power_fail;
    assign pins_async.sda   = i_sda;
    assign pins_async.scl   = i_scl;

    rtcs_sync #(
        .W         (rtcs_pkg::SYNC_RST_PINS),
        .RESET_VAL (rtcs_pkg::PINS_RESET)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    (pins_async),
        .o_sync     (pins_sync)
    );

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= pins_sync.scl;
            sda_q <= pins_sync.sda;
        end
    end

    assign scl_rise   = pins_sync.scl && !scl_q;
    assign scl_fall   = !pins_sync.scl && scl_q;
    // Only a data change while the clock stays high is a condition.
    assign start_cond = scl_q && pins_sync.scl && sda_q && !pins_sync.sda;
    assign stop_cond  = scl_q && pins_sync.scl && !sda_q && pins_sync.sda;

    // ------------------------------------------------------------
    // Power-fail guard
    // ------------------------------------------------------------
    logic [REC_W-1:0] rec_cnt;
    logic             blocked;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rec_cnt <= '0;
        end else if (pins_sync.pfail) begin
            // Reloading while the pin is high makes the delay run from the last deassertion.
            rec_cnt <= REC_W'(REC_CYCLES);
        end else if (rec_cnt != '0) begin
            rec_cnt <= rec_cnt - 1'b1;
        end
    end

    assign blocked = pins_sync.pfail || (rec_cnt != '0);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_access_blocked <= 1'b0;
        end else begin
            o_access_blocked <= blocked;
        end
    end

    // ------------------------------------------------------------
    // Bus busy tracking
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bus_busy <= 1'b0;
        end else if (start_cond) begin
            o_bus_busy <= 1'b1;
        end else if (stop_cond) begin
            o_bus_busy <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Write FIFO
    // ------------------------------------------------------------
    rtcs_pkg::rtcs_wr_t fifo_in;
    rtcs_pkg::rtcs_wr_t fifo_out;
    logic               fifo_push;
    logic               fifo_in_ready;
    logic               fifo_empty_n;

    rtcs_fifo #(
        .WIDTH ($bits(rtcs_pkg::rtcs_wr_t)),
        .DEPTH (rtcs_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk  (i_core_clk),
        .i_rst       (i_rst),
        .i_in_valid  (fifo_push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (fifo_in),
        .o_out_valid (fifo_empty_n),
        .i_out_ready (i_wr_ready),
        .o_out_data  (fifo_out)
    );

    assign o_wr_valid = fifo_empty_n;
    assign o_wr_addr  = fifo_out.addr;
    assign o_wr_data  = fifo_out.data;

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    rtcs_pkg::rtcs_state_t state;
    logic [3:0]            bit_cnt;
    logic [7:0]            rx_sr;
    logic [7:0]            tx_sr;
    logic                  read_dir;
    logic                  master_ack;
    logic [5:0]            ptr;
    logic                  run;
    logic                  byte_done;
    logic                  load_ok;
    logic                  ptr_load;
    logic                  ptr_inc;

    assign run       = !blocked && !start_cond && !stop_cond;
    assign byte_done = scl_fall && (bit_cnt == rtcs_pkg::BITS_BYTE);
    // Pending writes drain before a read so the byte sent is current.
    assign load_ok   = (state == rtcs_pkg::ST_RLOAD) && !fifo_empty_n;
    assign fifo_push = run && (state == rtcs_pkg::ST_WPUSH) && fifo_in_ready && !o_sda_oe;
    assign fifo_in.addr = ptr;
    assign fifo_in.data = rx_sr;
    assign o_rd_strobe  = run && load_ok;
    assign o_rd_addr    = ptr;
    assign ptr_load = run && byte_done && (state == rtcs_pkg::ST_WADDR);
    // The pointer moves on the clock fall that ends an acknowledge.
    assign ptr_inc  = run && scl_fall
                      && ((state == rtcs_pkg::ST_WDATA_ACK)
                          || ((state == rtcs_pkg::ST_RACK) && master_ack));

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state      <= rtcs_pkg::ST_IDLE;
            bit_cnt    <= '0;
            rx_sr      <= '0;
            tx_sr      <= '0;
            read_dir   <= 1'b0;
            master_ack <= 1'b0;
            o_sda_oe   <= 1'b0;
            o_scl_oe   <= 1'b0;
        end else if (blocked) begin
            state    <= rtcs_pkg::ST_IDLE;
            bit_cnt  <= '0;
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
        end else if (start_cond) begin
            state    <= rtcs_pkg::ST_ADDR;
            bit_cnt  <= '0;
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
        end else if (stop_cond) begin
            state    <= rtcs_pkg::ST_IDLE;
            bit_cnt  <= '0;
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
        end else begin
            unique case (state)
                rtcs_pkg::ST_IDLE, rtcs_pkg::ST_WAIT: begin
                    o_sda_oe <= 1'b0;
                end
                rtcs_pkg::ST_ADDR, rtcs_pkg::ST_WADDR, rtcs_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        rx_sr   <= {rx_sr[6:0], pins_sync.sda};
                        bit_cnt <= bit_cnt + 1'b1;
                    end else if (byte_done) begin
                        bit_cnt <= '0;
                        if (state == rtcs_pkg::ST_ADDR) begin
                            if (rx_sr[7:1] == rtcs_pkg::SLAVE_ADDR[7:1]) begin
                                read_dir <= rx_sr[0];
                                o_sda_oe <= 1'b1;
                                state    <= rtcs_pkg::ST_ADDR_ACK;
                            end else begin
                                state <= rtcs_pkg::ST_WAIT;
                            end
                        end else if (state == rtcs_pkg::ST_WADDR) begin
                            o_sda_oe <= 1'b1;
                            state    <= rtcs_pkg::ST_WADDR_ACK;
                        end else begin
                            o_scl_oe <= 1'b1;
                            state    <= rtcs_pkg::ST_WPUSH;
                        end
                    end
                end
                rtcs_pkg::ST_WPUSH: begin
                    // Clock is stretched low until the FIFO has room. The acknowledge goes
                    // out one cycle before the clock is let go, so it is set up in time.
                    if (o_sda_oe) begin
                        o_scl_oe <= 1'b0;
                        state    <= rtcs_pkg::ST_WDATA_ACK;
                    end else if (fifo_in_ready) begin
                        o_sda_oe <= 1'b1;
                    end
                end
                rtcs_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        o_sda_oe <= 1'b0;
                        if (read_dir) begin
                            o_scl_oe <= 1'b1;
                            state    <= rtcs_pkg::ST_RLOAD;
                        end else begin
                            state <= rtcs_pkg::ST_WADDR;
                        end
                    end
                end
                rtcs_pkg::ST_WADDR_ACK, rtcs_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        o_sda_oe <= 1'b0;
                        state    <= rtcs_pkg::ST_WDATA;
                    end
                end
                rtcs_pkg::ST_RLOAD: begin
                    if (load_ok) begin
                        tx_sr    <= i_rd_data;
                        o_sda_oe <= !i_rd_data[7];
                        bit_cnt  <= '0;
                        state    <= rtcs_pkg::ST_RDATA;
                    end
                end
                rtcs_pkg::ST_RDATA: begin
                    // The first bit is set up a cycle before the stretched clock is let go.
                    if (o_scl_oe) begin
                        o_scl_oe <= 1'b0;
                    end else if (scl_fall) begin
                        if (bit_cnt == rtcs_pkg::BITS_BYTE - 4'h1) begin
                            o_sda_oe <= 1'b0;
                            bit_cnt  <= '0;
                            state    <= rtcs_pkg::ST_RACK;
                        end else begin
                            tx_sr    <= {tx_sr[6:0], 1'b0};
                            o_sda_oe <= !tx_sr[6];
                            bit_cnt  <= bit_cnt + 1'b1;
                        end
                    end
                end
                rtcs_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        master_ack <= !pins_sync.sda;
                    end else if (scl_fall) begin
                        if (master_ack) begin
                            o_scl_oe <= 1'b1;
                            state    <= rtcs_pkg::ST_RLOAD;
                        end else begin
                            state <= rtcs_pkg::ST_WAIT;
                        end
                    end
                end
                default: begin
                    state    <= rtcs_pkg::ST_IDLE;
                    o_sda_oe <= 1'b0;
                    o_scl_oe <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Open-drain pin values
    // ------------------------------------------------------------
    // Both pins only ever pull low; the enables alone carry the level.
    assign o_sda_o = 1'b0;
    assign o_scl_o = 1'b0;

    // ------------------------------------------------------------
    // Address pointer
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ptr <= rtcs_pkg::LOC_CLOCK_LO;
        end else if (blocked) begin
            ptr <= rtcs_pkg::LOC_CLOCK_LO;
        end else if (ptr_load) begin
            ptr <= rx_sr[5:0];
        end else if (ptr_inc) begin
            // Six-bit counter wraps from the last RAM byte to zero.
            ptr <= ptr + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // Clock update freeze
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_clock_freeze <= 1'b0;
        end else begin
            o_clock_freeze <= !blocked
                              && ((state == rtcs_pkg::ST_RLOAD) || (state == rtcs_pkg::ST_RDATA)
                                  || (state == rtcs_pkg::ST_RACK))
                              && (ptr <= rtcs_pkg::LOC_CLOCK_HI);
        end
    end

endmodule : rtcs_slave
`default_nettype wire

// ---- rtcs_slave_assertions.sv ----
// Concurrent checks on the ports of the serial slave port.
`timescale 1ns/10ps
`default_nettype none
module rtcs_slave_assertions #(
    parameter int RECOVERY_DELAY_US = 1000
) (
    input wire logic       i_core_clk,
    input wire logic       i_rst,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       i_power_fail,
    input wire logic       i_wr_ready,
    input wire logic       o_scl_o,
    input wire logic       o_scl_oe,
    input wire logic       o_sda_o,
    input wire logic       o_sda_oe,
    input wire logic       o_wr_valid,
    input wire logic [5:0] o_wr_addr,
    input wire logic [7:0] o_wr_data,
    input wire logic [5:0] o_rd_addr,
    input wire logic       o_rd_strobe,
    input wire logic       o_clock_freeze,
    input wire logic       o_access_blocked,
    input wire logic       o_bus_busy
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_open_drain: assert property (!o_scl_o && !o_sda_o)
        else $error("pin output value is not low");
    a_fail_blocks: assert property ($rose(i_power_fail) |-> ##[1:4] o_access_blocked)
        else $error("power fail did not block access");
    a_blocked_quiet: assert property (o_access_blocked |-> !o_sda_oe && !o_scl_oe && !o_rd_strobe && o_rd_addr == 6'h00)
        else $error("blocked port still active");
    a_recovery_hold: assert property ($fell(i_power_fail) |-> o_access_blocked [*8])
        else $error("access opened before recovery");
    a_start_busy: assert property ($fell(i_sda) && i_scl && !i_power_fail && !o_access_blocked |-> ##[1:5] o_bus_busy)
        else $error("start not seen");
    a_stop_idle: assert property ($rose(i_sda) && i_scl && !i_power_fail && !o_access_blocked |-> ##[1:5] !o_bus_busy)
        else $error("stop not seen");
    a_sda_stable: assert property (disable iff (i_rst || i_power_fail) $changed(o_sda_oe) |-> !$past(i_scl))
        else $error("data drive changed while clock high");
    a_freeze_range: assert property (o_rd_addr > 6'h07 && $past(o_rd_addr) > 6'h07 |-> !o_clock_freeze)
        else $error("freeze held outside clock locations");
    a_write_hold: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data))
        else $error("pending write changed");
    a_strobe_pulse: assert property (o_rd_strobe |-> o_scl_oe ##1 !o_rd_strobe)
        else $error("read strobe outside a held clock");
endmodule : rtcs_slave_assertions
bind rtcs_slave rtcs_slave_assertions #(.RECOVERY_DELAY_US(RECOVERY_DELAY_US)) i_rtcs_slave_assertions (
    .i_core_clk, .i_rst, .i_scl, .i_sda, .i_power_fail, .i_wr_ready, .o_scl_o, .o_scl_oe, .o_sda_o,
    .o_sda_oe, .o_wr_valid, .o_wr_addr, .o_wr_data, .o_rd_addr, .o_rd_strobe, .o_clock_freeze,
    .o_access_blocked, .o_bus_busy
);
`default_nettype wire

// ---- rtcs_master.sv ----
// Bus master model driving the serial clock and data lines.
`timescale 1ns/10ps
`default_nettype none
module rtcs_master (
    input  wire logic i_core_clk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output var logic  o_scl,
    output var logic  o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic hc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : hc
    // One clock pulse; a stretched clock is waited out and data is sampled mid-high.
    task automatic bit_cyc(input logic b, output logic s);
        int w;
        hc(2);
        o_sda = b;
        hc(2);
        o_scl = 1'b1;
        for (w = 0; w < 4000 && i_scl !== 1'b1; w++) hc(1);
        hc(2);
        s = i_sda;
        hc(2);
        o_scl = 1'b0;
    endtask : bit_cyc
    task automatic start;
        hc(2);
        o_sda = 1'b1;
        hc(2);
        o_scl = 1'b1;
        hc(4);
        o_sda = 1'b0;
        hc(4);
        o_scl = 1'b0;
    endtask : start
    task automatic stop;
        hc(2);
        o_sda = 1'b0;
        hc(2);
        o_scl = 1'b1;
        hc(4);
        o_sda = 1'b1;
        hc(4);
    endtask : stop
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
        bit_cyc(1'b1, s);
        ack = ~s;
    endtask : wbyte
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
        bit_cyc(~ack, s);
    endtask : rbyte
endmodule : rtcs_master
`default_nettype wire

// ---- test_rtcs_slave.sv ----
// Self-checking testbench for the serial slave port.
`timescale 1ns/10ps
`default_nettype none
module test_rtcs_slave;
    logic       clk, rst, m_scl, m_sda, pfail, wr_ready;
    logic       scl_oe, sda_oe, wr_valid, freeze, blocked, busy;
    logic [5:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data;
    logic [7:0] mem [64];
    wire logic  scl_w = m_scl & ~scl_oe;
    wire logic  sda_w = m_sda & ~sda_oe;
    int         miscompares = 0;
    int         comparisons = 0;
    rtcs_slave #(.RECOVERY_DELAY_US(1)) i_rtcs_slave (
        .i_core_clk(clk), .i_rst(rst), .i_scl(scl_w), .o_scl_o(), .o_scl_oe(scl_oe),
        .i_sda(sda_w), .o_sda_o(), .o_sda_oe(sda_oe), .i_power_fail(pfail), .o_wr_valid(wr_valid),
        .i_wr_ready(wr_ready), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_addr(rd_addr),
        .o_rd_strobe(), .i_rd_data(rd_data), .o_clock_freeze(freeze), .o_access_blocked(blocked),
        .o_bus_busy(busy)
    );
    rtcs_master i_rtcs_master (.i_core_clk(clk), .i_scl(scl_w), .i_sda(sda_w), .o_scl(m_scl), .o_sda(m_sda));
    // The array answers reads at once and takes writes whenever ready is high.
    assign rd_data = mem[rd_addr];
    always @(posedge clk) if (wr_valid && wr_ready) mem[wr_addr] <= wr_data;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic end_sim;
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic hc(input int n);
        repeat (n) @(negedge clk);
    endtask : hc
    task automatic wb(input logic [7:0] d, input logic e);
        logic a;
        i_rtcs_master.wbyte(d, a);
        chk("ack", 8'(e), 8'(a));
    endtask : wb
    task automatic rb(input logic ack, input logic [7:0] e);
        logic [7:0] d;
        i_rtcs_master.rbyte(ack, d);
        chk("read data", e, d);
    endtask : rb
    task automatic t_write;
        i_rtcs_master.start();
        wb(8'hD0, 1'b1);
        wb(8'h3E, 1'b1);
        wb(8'hA5, 1'b1);
        wb(8'h5A, 1'b1);
        wb(8'hC3, 1'b1);
        chk("busy", 8'h01, 8'(busy));
        i_rtcs_master.stop();
        hc(8);
        chk("busy", 8'h00, 8'(busy));
        chk("mem 3E", 8'hA5, mem[6'h3E]);
        chk("mem 3F", 8'h5A, mem[6'h3F]);
        chk("mem 00", 8'hC3, mem[6'h00]);
        chk("pointer", 8'h01, 8'(rd_addr));
    endtask : t_write
    task automatic t_wrong;
        i_rtcs_master.start();
        wb(8'hA0, 1'b0);
        i_rtcs_master.stop();
    endtask : t_wrong
    task automatic t_read;
        i_rtcs_master.start();
        wb(8'hD0, 1'b1);
        wb(8'h06, 1'b1);
        i_rtcs_master.start();
        wb(8'hD1, 1'b1);
        rb(1'b1, 8'hC6);
        chk("freeze", 8'h01, 8'(freeze));
        rb(1'b1, 8'hC7);
        rb(1'b0, 8'hC8);
        hc(4);
        chk("sda", 8'h01, 8'(sda_w));
        chk("pointer", 8'h08, 8'(rd_addr));
        chk("freeze", 8'h00, 8'(freeze));
        i_rtcs_master.stop();
        i_rtcs_master.start();
        wb(8'hD1, 1'b1);
        rb(1'b0, 8'hC8);
        i_rtcs_master.stop();
    endtask : t_read
    task automatic t_fifo;
        wr_ready = 1'b0;
        fork
            begin
                i_rtcs_master.start();
                wb(8'hD0, 1'b1);
                wb(8'h14, 1'b1);
                for (int i = 0; i < 10; i++) wb(8'h30 + 8'(i), 1'b1);
                i_rtcs_master.stop();
            end
            begin
                hc(1500);
                chk("stretch", 8'h01, 8'(scl_oe));
                chk("head", 8'h14, 8'(wr_addr));
                wr_ready = 1'b1;
            end
        join
        for (int i = 0; i < 10; i++) chk("mem", 8'h30 + 8'(i), mem[6'h14 + 6'(i)]);
    endtask : t_fifo
    task automatic t_pfail;
        logic a;
        i_rtcs_master.start();
        wb(8'hD0, 1'b1);
        wb(8'h20, 1'b1);
        fork
            i_rtcs_master.wbyte(8'h22, a);
            begin
                hc(30);
                pfail = 1'b1;
            end
        join
        chk("blocked", 8'h01, 8'(blocked));
        chk("pointer", 8'h00, 8'(rd_addr));
        i_rtcs_master.stop();
        i_rtcs_master.start();
        wb(8'hD0, 1'b0);
        i_rtcs_master.stop();
        pfail = 1'b0;
        hc(100);
        chk("blocked", 8'h01, 8'(blocked));
        hc(40);
        chk("blocked", 8'h00, 8'(blocked));
        chk("mem 20", 8'hE0, mem[6'h20]);
        i_rtcs_master.start();
        wb(8'hD0, 1'b1);
        i_rtcs_master.stop();
    endtask : t_pfail
    initial begin
        #60000;
        miscompares++;
        end_sim();
    end
    initial begin
        rst = 1'b1;
        pfail = 1'b0;
        wr_ready = 1'b1;
        for (int i = 0; i < 64; i++) mem[i] = 8'hC0 ^ 8'(i);
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        hc(4);
        t_write();
        t_wrong();
        t_read();
        t_fifo();
        t_pfail();
        end_sim();
    end
endmodule : test_rtcs_slave
`default_nettype wire
